//--- rtl/ldo_regulator_control.sv
// control and status register for the on-chip ldo regulator
// assumes a cpu sfr port on clk_sys and a raw dropout comparator level from the analog side
// interrupt enable and priority live in the interrupt controller, not here
// Functional notes
// R1: output level select bit: 0 picks 2.1V, 1 picks 2.6V.
// R2: bit 7 is read/write disable; 0 enabled, 1 regulator off.
// R3: regulator enabled after any reset until software sets disable.
// R4: dropout request asserted while input below threshold; gated outside by enable.
// R5: dropout request is not latched; follows the live condition.
// R6: bit 0 is read-only dropout indicator, cleared only by hardware.
// R7: bit 6 reserved, reads one; software must write one there.
// R8: bits 5 and 3:1 read zero; writes to them ignored.
// R9: software disables interrupt in handler, re-enables after indicator clears.
// R10: control register reads 0x50 after reset.

`timescale 1ns/1ns
`default_nettype none
module ldo_regulator_control
   import ldo_regulator_pkg::*;
(
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   input  wire ldo_regulator_pkg::sfr_req_s  sfr_req,
   output logic      [7:0]                   sfr_rdata,
   input  wire logic                         dropout_raw,
   output logic                              regulator_disable,
   output logic                              output_level_select,
   output logic                              dropout_irq
);
   import ldo_regulator_pkg::*;

   // every decode keys on the one register address
   function automatic logic hit(
      input sfr_req_s r
   );
      return r.addr == regulator_control_addr;
   endfunction

   // write strobe on our address
   function automatic logic write_hit(
      input sfr_req_s r
   );
      return r.wr && hit(r);
   endfunction

   // read strobe on our address
   function automatic logic read_hit(
      input sfr_req_s r
   );
      return r.rd && hit(r);
   endfunction

   // picks one bit out of the write byte
   // index comes from the package so the map lives in one place
   function automatic logic field(
      input logic [7:0] b,
      input int         idx
   );
      return b[idx];
   endfunction

   // the filter trusts a level only once two late stages hold it
   function automatic logic stage_agree(
      input logic [sync_stages-1:0] q
   );
      return q[1] == q[2];
   endfunction

   // one bit of the byte software reads; anything unnamed reads zero
   // reserved bit is a constant, so a bad software write cannot flip it
   function automatic logic view_bit(
      input int        idx,
      input ldo_ctrl_s c,
      input logic      d
   );
      logic b;

      b = 1'b0;

      case (idx)
         disable_bit: begin
            b = c.regulator_disable;   // R2
         end

         reserved_bit: begin
            b = reserved_read_value;   // R7
         end

         level_bit: begin
            b = c.output_level_select; // R1
         end

         dropout_bit: begin
            b = d;                     // R6
         end

         default: begin
            b = 1'b0;                  // R8
         end
      endcase

      return b;
   endfunction

   // request decode
   logic                   wr_hit;
   logic                   rd_hit;

   // dropout path
   logic [sync_stages-1:0] sync_q;
   logic [sync_stages-1:0] sync_d;
   logic                   agree;
   logic                   drop_q;
   logic                   drop_d;

   // control byte
   ldo_ctrl_s              ctrl_q;
   ldo_ctrl_s              ctrl_d;

   // read path
   logic [7:0]             reg_view;
   logic [7:0]             rdata_q;
   logic [7:0]             rdata_d;

   // decoded once, shared by both paths
   always_comb begin
      wr_hit = write_hit(sfr_req);
      rd_hit = read_hit(sfr_req);
   end

   // comparator level is asynchronous; only stage two ever reads stage one
   for (genvar s = 0; s < sync_stages; s++) begin : g_sync
      if (s == 0) begin : g_first
         assign sync_d[s] = dropout_raw;
      end else begin : g_next
         assign sync_d[s] = sync_q[s-1];
      end

      // chain cleared on reset so no stale dropout survives it
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            sync_q[s] <= 1'b0;
         end else begin
            sync_q[s] <= sync_d[s];
         end
      end
   end

   // a change counts once stages two and three agree; costs a cycle, rejects one-cycle glitches
   always_comb begin
      agree = stage_agree(sync_q);

      if (agree) begin
         drop_d = sync_q[2];
      end else begin
         drop_d = drop_q;
      end
   end

   // indicator starts clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         drop_q <= regulator_control_rst[dropout_bit];
      end else begin
         drop_q <= drop_d;
      end
   end

   // only disable and level are stored; bits 6, 5, 3:1 and 0 of a write fall away
   always_comb begin
      if (wr_hit) begin
         ctrl_d.regulator_disable   = field(sfr_req.wdata, disable_bit); // R2
         ctrl_d.output_level_select = field(sfr_req.wdata, level_bit);   // R1
      end else begin
         ctrl_d = ctrl_q;
      end
   end

   // enabled out of reset; software has to ask to turn it off
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q.regulator_disable   <= regulator_control_rst[disable_bit]; // R3 R10
         ctrl_q.output_level_select <= regulator_control_rst[level_bit];   // R10
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // read byte built a bit at a time from the map above
   for (genvar i = 0; i < 8; i++) begin : g_view
      assign reg_view[i] = view_bit(i, ctrl_q, drop_q);
   end

   // zero when not reading, so a stale byte never lingers on the port
   always_comb begin
      if (rd_hit) begin
         rdata_d = reg_view;
      end else begin
         rdata_d = 8'h00;
      end
   end

   // one cycle of read latency, traded for a clean flop output
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // read data straight from its flop
   assign sfr_rdata           = rdata_q;

   // levels come from flops, so the analog side never sees a decode glitch
   assign regulator_disable   = ctrl_q.regulator_disable;   // R2
   assign output_level_select = ctrl_q.output_level_select; // R1
   // no pending flag; the interrupt controller gates this level with its enable
   assign dropout_irq         = drop_q;                     // R4 R5

endmodule
`default_nettype wire

//--- rtl/ldo_regulator_pkg.sv
// package for the ldo regulator control block
// assumes an 8-bit special-function-register port on the system clock
package ldo_regulator_pkg;

   localparam logic [7:0] regulator_control_addr = 8'hc9;
   localparam int         disable_bit            = 7;
   localparam int         reserved_bit           = 6;
   localparam int         level_bit              = 4;
   localparam int         dropout_bit            = 0;
   localparam logic [7:0] regulator_control_rst  = 8'h50;
   localparam logic       reserved_read_value    = 1'h1;
   localparam logic       level_high             = 1'h1;
   localparam logic       level_low              = 1'h0;
   localparam int         sync_stages            = 3;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic       regulator_disable;
      logic       output_level_select;
   } ldo_ctrl_s;

endpackage

//--- tb/ldo_regulator_control_sva.sv
// port checker for ldo_regulator_control
// assumes bind onto the design top, below
`timescale 1ns/1ns
`default_nettype none
module ldo_regulator_control_sva import ldo_regulator_pkg::*; (input wire logic clk_sys, rst, dropout_raw,
   regulator_disable, output_level_select, dropout_irq, input wire ldo_regulator_pkg::sfr_req_s sfr_req,
   input wire logic [7:0] sfr_rdata);
   wire logic h = sfr_req.addr == regulator_control_addr;
   wire logic w = sfr_req.wr && h;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_dis_write: assert property (w |=> regulator_disable == $past(sfr_req.wdata[7])) else $error("dis");
   chk_lvl_write: assert property (w |=> output_level_select == $past(sfr_req.wdata[4])) else $error("lvl");
   chk_ctrl_hold: assert property (!w |=> $stable(regulator_disable)) else $error("hold");
   chk_miss_ign: assert property (sfr_req.wr && !h |=> $stable(output_level_select)) else $error("miss");
   chk_read_map: assert property (sfr_req.rd && h |=> sfr_rdata == {$past(regulator_disable), 2'h2,
      $past(output_level_select), 3'h0, $past(dropout_irq)}) else $error("read");
   sequence raw_high_run;
      dropout_raw [*5];
   endsequence
   sequence raw_low_run;
      !dropout_raw [*5];
   endsequence
   chk_drop_rise: assert property (raw_high_run |-> dropout_irq) else $error("rise");
   chk_drop_fall: assert property (raw_low_run |-> !dropout_irq) else $error("fall");
   chk_rst_val: assert property (disable iff (1'b0) rst |=> !regulator_disable && output_level_select) else $error("rst");
endmodule
bind ldo_regulator_control ldo_regulator_control_sva ldo_regulator_control_sva_i (.*);
`default_nettype wire

//--- tb/ldo_regulator_control_tb.sv
// bench for ldo_regulator_control
// assumes the checker binds itself
`timescale 1ns/1ns
`default_nettype none
`define chk(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t bad", $time); end end
module ldo_regulator_control_tb;
   import ldo_regulator_pkg::*;
   logic clk_sys = 0, rst = 1, dropout_raw = 0, regulator_disable, output_level_select, dropout_irq, ds = 0, lv = 1;
   sfr_req_s sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic [31:0] r = 32'h2274796b;
   int n_fail = 0, checks = 0, cyc = 0;
   always #2 clk_sys = ~clk_sys;
   ldo_regulator_control ldo_regulator_control_i (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic results;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("== PASSED =="); else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cyc > 999) begin n_fail++; results; end
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 0;
      for (int i = 0; i < 40; i++) begin
         r = lfsr(r);
         dropout_raw = r[9];
         repeat (4) @(negedge clk_sys);
         sfr_req = '{1'b0, 1'b1, 8'hc9, 8'h00};
         @(negedge clk_sys);
         `chk(sfr_rdata, {ds, 2'h2, lv, 3'h0, r[9]})
         `chk({dropout_irq, regulator_disable, output_level_select}, {r[9], ds, lv})
         // half the writes miss the decoder
         sfr_req = '{1'b1, 1'b0, r[8] ? 8'hc9 : 8'h3c, r[7:0] | 8'h40};
         if (r[8]) begin ds = r[7]; lv = r[4]; end
         @(negedge clk_sys);
         sfr_req = '0;
         $display("test %0d done", i);
      end
      // mid-run reset must bring back the enabled, high-level state
      dropout_raw = 1'b0;
      repeat (5) @(negedge clk_sys);
      rst = 1;
      repeat (2) @(negedge clk_sys);
      rst = 0;
      sfr_req = '{1'b0, 1'b1, 8'hc9, 8'h00};
      @(negedge clk_sys);
      sfr_req = '0;
      `chk(sfr_rdata, regulator_control_rst)
      `chk({regulator_disable, output_level_select, dropout_irq}, 3'h2)
      @(negedge clk_sys);
      `chk(sfr_rdata, 8'h00)
      $display("test reset done");
      results;
   end
endmodule
`default_nettype wire
